/* File: design/plsaic_top.sv */
// indicator select, receive error counter and interrupt control registers
// Notes on behaviour
// - each indicator field is three bits choosing link, activity, tx, rx, collision, speed, duplex or code 7.
// - the fourth indicator field sits at bits 11..9, resets to 7, and 7 turns that output off.
// - the third indicator field sits at bits 8..6, resets to 7, and 7 turns that output off.
// - the second indicator field sits at bits 5..3, resets to 5 (speed), and 7 turns it off.
// - the first indicator field sits at bits 2..0, resets to 1 (activity), and 7 shows link status.
// - a 16-bit read/write counter counts receive errors while the reduced-pin mode is active.
// - the interrupt pin is driven only when the enable bit is set, low-active at polarity 0.
// - with read-clear on, reading the flags clears them; with it off, reads leave them alone.
// - with auto-clear on, a flag drops once its condition goes; off, it holds.
// - writing 1 to a flag clears it, unless the hold bit is set and its condition is present.
// - eleven enable bits, all reset to 0, gate the eleven interrupt events.
// - each event has a write-one-to-clear flag, reset to 0, recording that it occurred.
`timescale 1ns/1ps
`default_nettype none
module plsaic_top #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  input  wire logic        link_ok,
  input  wire logic        activity,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        collision,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        rmii_mode,
  input  wire logic        rx_error,
  input  wire logic [10:0] irq_cond,
  output logic [3:0]       ind_out,
  output logic             irq_o,
  output logic             irq_oe
);
  logic        rd_stb, wr_stb;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data, rd_data;
  logic [11:0] sel_r, sel_nxt;
  logic [15:0] cnt_r, cnt_nxt, ctl_r, ctl_nxt;
  logic [10:0] flag_r, flag_nxt, cond_d_r, evt_set, flag_clr;
  logic [3:0]  ind_r, ind_nxt;
  logic        irq_o_r, irq_o_nxt, irq_oe_r, irq_oe_nxt, pend;

  plsaic_mdio #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .mdc      (mdc),
    .mdio_i   (mdio_i),
    .rd_data  (rd_data),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .rd_stb   (rd_stb),
    .wr_stb   (wr_stb),
    .reg_addr (reg_addr),
    .wr_data  (wr_data)
  );

  function automatic logic ind_src(input logic [2:0] code, input logic alt);
    case (code)
      plsaic_pkg::SRC_LINK:  ind_src = link_ok;
      plsaic_pkg::SRC_ACT:   ind_src = activity;
      plsaic_pkg::SRC_TXD:   ind_src = tx_active;
      plsaic_pkg::SRC_RXD:   ind_src = rx_active;
      plsaic_pkg::SRC_COL:   ind_src = collision;
      plsaic_pkg::SRC_SPEED: ind_src = speed_100;
      plsaic_pkg::SRC_FDX:   ind_src = full_duplex;
      default:               ind_src = alt;
    endcase
  endfunction : ind_src

  // read mux; unused upper bits and unmapped offsets read as zero
  always_comb begin
    case (reg_addr)
      plsaic_pkg::REG_IND_SEL:   rd_data = {4'h0, sel_r};
      plsaic_pkg::REG_RXERR_CNT: rd_data = cnt_r;
      plsaic_pkg::REG_IRQ_CTL:   rd_data = ctl_r;
      plsaic_pkg::REG_IRQ_FLAG:  rd_data = {5'h00, flag_r};
      default:                   rd_data = 16'h0000;
    endcase
  end

  // event edges and the clear sources for the flags
  always_comb begin
    evt_set = irq_cond & ~cond_d_r;
    flag_clr = 11'h000;
    if (ctl_r[plsaic_pkg::CTL_AUTO_CLR]) begin
      flag_clr = flag_clr | ~irq_cond;
    end
    if (rd_stb && reg_addr == plsaic_pkg::REG_IRQ_FLAG && ctl_r[plsaic_pkg::CTL_RD_CLR]) begin
      flag_clr = 11'h7ff;
    end
    if (wr_stb && reg_addr == plsaic_pkg::REG_IRQ_FLAG) begin
      flag_clr = flag_clr | (wr_data[10:0] &
                 (ctl_r[plsaic_pkg::CTL_HOLD] ? ~irq_cond : 11'h7ff));
    end
  end

  // register bank next values; a new event beats a clear in the same cycle
  always_comb begin
    sel_nxt = sel_r;
    cnt_nxt = cnt_r;
    ctl_nxt = ctl_r;
    flag_nxt = evt_set | (flag_r & ~flag_clr);
    if (wr_stb && reg_addr == plsaic_pkg::REG_IND_SEL) begin
      sel_nxt = wr_data[11:0];
    end
    if (wr_stb && reg_addr == plsaic_pkg::REG_IRQ_CTL) begin
      ctl_nxt = wr_data;
    end
    if (wr_stb && reg_addr == plsaic_pkg::REG_RXERR_CNT) begin
      cnt_nxt = wr_data;
    end else if (rmii_mode && rx_error && cnt_r != plsaic_pkg::RXERR_CNT_MAX) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  assign pend = |(flag_r & ctl_r[10:0]);

  // outputs registered so pins never glitch during decode
  always_comb begin
    ind_nxt[3] = ind_src(sel_r[plsaic_pkg::IND_FOUR_LSB +: 3], 1'b0);
    ind_nxt[2] = ind_src(sel_r[plsaic_pkg::IND_THREE_LSB +: 3], 1'b0);
    ind_nxt[1] = ind_src(sel_r[plsaic_pkg::IND_TWO_LSB +: 3], 1'b0);
    // first indicator, code 7 is link
    ind_nxt[0] = ind_src(sel_r[plsaic_pkg::IND_ONE_LSB +: 3], link_ok);
    irq_oe_nxt = ctl_r[plsaic_pkg::CTL_OUT_EN];
    irq_o_nxt = ctl_r[plsaic_pkg::CTL_POL] ? pend : ~pend;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_r <= plsaic_pkg::IND_SEL_RST;
      cnt_r <= plsaic_pkg::RXERR_CNT_RST;
      ctl_r <= plsaic_pkg::IRQ_CTL_RST;
      flag_r <= plsaic_pkg::IRQ_FLAG_RST;
      cond_d_r <= 11'h000;
      ind_r <= 4'h0;
      irq_o_r <= 1'b1;
      irq_oe_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      cnt_r <= cnt_nxt;
      ctl_r <= ctl_nxt;
      flag_r <= flag_nxt;
      cond_d_r <= irq_cond;
      ind_r <= ind_nxt;
      irq_o_r <= irq_o_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  assign ind_out = ind_r;
  assign irq_o   = irq_o_r;
  assign irq_oe  = irq_oe_r;

  // checks on indicator, counter and interrupt behaviour
  sequence s_flag_read;
    rd_stb && reg_addr == plsaic_pkg::REG_IRQ_FLAG;
  endsequence
  sequence s_no_event;
    !(|evt_set) && !wr_stb;
  endsequence

  property p_ind_four_off;
    @(posedge clk) disable iff (sys_rst) sel_r[11:9] == 3'h7 |=> !ind_r[3];
  endproperty
  a_ind_four_off: assert property (p_ind_four_off) else $error("fourth indicator not off");
  property p_ind_three_off;
    @(posedge clk) disable iff (sys_rst) sel_r[8:6] == 3'h7 |=> !ind_r[2];
  endproperty
  a_ind_three_off: assert property (p_ind_three_off) else $error("third indicator not off");
  property p_ind_two_speed;
    @(posedge clk) disable iff (sys_rst) sel_r[5:3] == 3'h5 |=> ind_r[1] == $past(speed_100);
  endproperty
  a_ind_two_speed: assert property (p_ind_two_speed) else $error("second indicator not speed");
  property p_ind_one_link;
    @(posedge clk) disable iff (sys_rst) sel_r[2:0] == 3'h7 |=> ind_r[0] == $past(link_ok);
  endproperty
  a_ind_one_link: assert property (p_ind_one_link) else $error("first indicator not link");
  property p_cnt_inc;
    @(posedge clk) disable iff (sys_rst)
      rmii_mode && rx_error && !wr_stb && cnt_r != 16'hffff |=> cnt_r == $past(cnt_r) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("error count did not step");
  property p_irq_pin;
    @(posedge clk) disable iff (sys_rst)
      pend |=> irq_o_r == $past(ctl_r[13]) && irq_oe_r == $past(ctl_r[15]);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin level wrong");
  property p_rd_clear;
    @(posedge clk) disable iff (sys_rst) s_flag_read and ctl_r[14] and s_no_event |=> flag_r == 11'h000;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read");
  property p_rd_keep;
    @(posedge clk) disable iff (sys_rst)
      s_flag_read and !ctl_r[14] and !ctl_r[12] |=> (($past(flag_r) & ~flag_r) == 11'h000);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("flags lost on plain read");
  property p_auto_clr;
    @(posedge clk) disable iff (sys_rst) ctl_r[12] && irq_cond == 11'h000 |=> flag_r == 11'h000;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("flag not auto cleared");
  property p_hold_write;
    @(posedge clk) disable iff (sys_rst)
      wr_stb && reg_addr == plsaic_pkg::REG_IRQ_FLAG && ctl_r[11] && !ctl_r[12] && !ctl_r[14]
      |=> (flag_r & $past(irq_cond)) == (($past(flag_r) | $past(evt_set)) & $past(irq_cond));
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("held flag was cleared");
  property p_flag_set;
    @(posedge clk) disable iff (sys_rst) |evt_set |=> (flag_r & $past(evt_set)) == $past(evt_set);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event not recorded");
  property p_irq_idle;
    @(posedge clk) disable iff (sys_rst) !pend ##1 !pend |-> irq_o_r == !$past(ctl_r[13]);
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("pin asserted with nothing pending");
endmodule : plsaic_top
`default_nettype wire

/* File: design/plsaic_pkg.sv */
// constants, field layout and state codes for the indicator and interrupt control block
`default_nettype none
package plsaic_pkg;
  // register offsets on the management bus
  localparam logic [4:0]  REG_IND_SEL    = 5'h14;
  localparam logic [4:0]  REG_RXERR_CNT  = 5'h15;
  localparam logic [4:0]  REG_IRQ_CTL    = 5'h16;
  localparam logic [4:0]  REG_IRQ_FLAG   = 5'h17;
  // indicator select field positions (low bit of each 3-bit field)
  localparam int          IND_FOUR_LSB   = 9;
  localparam int          IND_THREE_LSB  = 6;
  localparam int          IND_TWO_LSB    = 3;
  localparam int          IND_ONE_LSB    = 0;
  localparam int          IND_SEL_W      = 12;
  localparam logic [11:0] IND_SEL_RST    = 12'hfe9;
  // indicator source codes
  localparam logic [2:0]  SRC_LINK       = 3'h0;
  localparam logic [2:0]  SRC_ACT        = 3'h1;
  localparam logic [2:0]  SRC_TXD        = 3'h2;
  localparam logic [2:0]  SRC_RXD        = 3'h3;
  localparam logic [2:0]  SRC_COL        = 3'h4;
  localparam logic [2:0]  SRC_SPEED      = 3'h5;
  localparam logic [2:0]  SRC_FDX        = 3'h6;
  localparam logic [2:0]  SRC_ALT        = 3'h7;
  // interrupt control bit positions
  localparam int          CTL_OUT_EN     = 15;
  localparam int          CTL_RD_CLR     = 14;
  localparam int          CTL_POL        = 13;
  localparam int          CTL_AUTO_CLR   = 12;
  localparam int          CTL_HOLD       = 11;
  localparam int          NUM_EVT        = 11;
  localparam logic [15:0] IRQ_CTL_RST    = 16'h0000;
  localparam logic [10:0] IRQ_FLAG_RST   = 11'h000;
  localparam logic [15:0] RXERR_CNT_RST  = 16'h0000;
  localparam logic [15:0] RXERR_CNT_MAX  = 16'hffff;
  // management frame layout
  localparam logic [5:0]  PRE_LEN        = 6'h20;
  localparam logic [1:0]  OP_RD          = 2'h2;
  localparam logic [1:0]  OP_WR          = 2'h1;
  localparam logic [4:0]  HDR_LAST       = 5'h0b;
  localparam logic [4:0]  DATA_LAST      = 5'h0f;

  typedef enum logic [2:0] {
    S_PRE  = 3'b000,
    S_ST   = 3'b001,
    S_HDR  = 3'b010,
    S_TA   = 3'b011,
    S_DATA = 3'b100
  } plsaic_mdio_st_e;
endpackage : plsaic_pkg
`default_nettype wire

/* File: design/plsaic_mdio.sv */
// management serial frame engine: preamble, header, turnaround and data phases
`timescale 1ns/1ps
`default_nettype none
module plsaic_mdio #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  input  wire logic [15:0] rd_data,
  output logic             mdio_o,
  output logic             mdio_oe,
  output logic             rd_stb,
  output logic             wr_stb,
  output logic [4:0]       reg_addr,
  output logic [15:0]      wr_data
);
  logic mdc_s1_r, mdc_s2_r, mdc_s3_r, dio_s1_r, dio_s2_r;
  logic rise, bit_in;
  plsaic_pkg::plsaic_mdio_st_e st_r, st_nxt;
  logic [5:0]  pre_r, pre_nxt;
  logic [4:0]  cnt_r, cnt_nxt, addr_r, addr_nxt;
  logic [11:0] hdr_r, hdr_nxt, hdr_full;
  logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt, wdat_r, wdat_nxt;
  logic        is_rd_r, is_rd_nxt, is_wr_r, is_wr_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic        o_r, o_nxt, oe_r, oe_nxt;

  // two-stage synchronisers; the third mdc stage only feeds the edge detector
  always_ff @(posedge clk) begin
    mdc_s1_r <= mdc;
    mdc_s2_r <= mdc_s1_r;
    mdc_s3_r <= mdc_s2_r;
    dio_s1_r <= mdio_i;
    dio_s2_r <= dio_s1_r;
  end

  assign rise     = mdc_s2_r & ~mdc_s3_r;
  assign bit_in   = dio_s2_r;
  assign hdr_full = {hdr_r[10:0], bit_in};

  // frame decode; output bits change just after the rising mdc edge
  always_comb begin
    st_nxt = st_r;
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    wdat_nxt = wdat_r;
    addr_nxt = addr_r;
    is_rd_nxt = is_rd_r;
    is_wr_nxt = is_wr_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    o_nxt = o_r;
    oe_nxt = oe_r;
    if (rd_r) begin
      tx_nxt = rd_data; // sampled in the same cycle the flags may clear
    end
    if (rise) begin
      case (st_r)
        plsaic_pkg::S_PRE: begin
          if (bit_in) begin
            pre_nxt = (pre_r == plsaic_pkg::PRE_LEN) ? pre_r : pre_r + 6'h01;
          end else if (pre_r == plsaic_pkg::PRE_LEN) begin
            st_nxt = plsaic_pkg::S_ST;
          end else begin
            pre_nxt = 6'h00;
          end
        end
        plsaic_pkg::S_ST: begin
          st_nxt = bit_in ? plsaic_pkg::S_HDR : plsaic_pkg::S_PRE;
          pre_nxt = 6'h00;
          cnt_nxt = 5'h00;
        end
        plsaic_pkg::S_HDR: begin
          hdr_nxt = hdr_full;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == plsaic_pkg::HDR_LAST) begin
            is_rd_nxt = (hdr_full[9:5] == PHY_ADDR) && (hdr_full[11:10] == plsaic_pkg::OP_RD);
            is_wr_nxt = (hdr_full[9:5] == PHY_ADDR) && (hdr_full[11:10] == plsaic_pkg::OP_WR);
            rd_nxt = (hdr_full[9:5] == PHY_ADDR) && (hdr_full[11:10] == plsaic_pkg::OP_RD);
            addr_nxt = hdr_full[4:0];
            st_nxt = plsaic_pkg::S_TA;
            cnt_nxt = 5'h00;
          end
        end
        plsaic_pkg::S_TA: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == 5'h00) begin
            oe_nxt = is_rd_r; // second turnaround bit is driven low
            o_nxt = 1'b0;
          end else begin
            st_nxt = plsaic_pkg::S_DATA;
            cnt_nxt = 5'h00;
            o_nxt = is_rd_r & tx_r[15];
            tx_nxt = {tx_r[14:0], 1'b0};
          end
        end
        plsaic_pkg::S_DATA: begin
          rx_nxt = {rx_r[14:0], bit_in};
          cnt_nxt = cnt_r + 5'h01;
          o_nxt = is_rd_r & tx_r[15];
          tx_nxt = {tx_r[14:0], 1'b0};
          if (cnt_r == plsaic_pkg::DATA_LAST) begin
            oe_nxt = 1'b0;
            o_nxt = 1'b0;
            wr_nxt = is_wr_r;
            wdat_nxt = {rx_r[14:0], bit_in};
            st_nxt = plsaic_pkg::S_PRE;
            pre_nxt = 6'h00;
          end
        end
        default: st_nxt = plsaic_pkg::S_PRE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= plsaic_pkg::S_PRE;
      pre_r <= 6'h00;
      cnt_r <= 5'h00;
      hdr_r <= 12'h000;
      rx_r <= 16'h0000;
      tx_r <= 16'h0000;
      wdat_r <= 16'h0000;
      addr_r <= 5'h00;
      is_rd_r <= 1'b0;
      is_wr_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      o_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      wdat_r <= wdat_nxt;
      addr_r <= addr_nxt;
      is_rd_r <= is_rd_nxt;
      is_wr_r <= is_wr_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      o_r <= o_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign mdio_o   = o_r;
  assign mdio_oe  = oe_r;
  assign rd_stb   = rd_r;
  assign wr_stb   = wr_r;
  assign reg_addr = addr_r;
  assign wr_data  = wdat_r;
endmodule : plsaic_mdio
`default_nettype wire

/* File: test/plsaic_sta.sv */
// station manager model driving the management clock and data pin
`timescale 1ns/1ps
`default_nettype none
module plsaic_sta (
  input  wire logic clk,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_i
);
  logic sta_o;
  logic sta_oe;
  int   half;

  // idle: clock parked low, data released
  initial begin
    mdc    = 1'b0;
    sta_o  = 1'b1;
    sta_oe = 1'b0;
    half   = 5;
  end

  // pin level: device first, then us, else the pull-up
  assign mdio_i = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);

  // one bit: data set while clock low, sampled as clock rises
  task automatic bit_cyc(input logic b, input logic drv, output logic s);
    @(posedge clk);
    mdc    <= 1'b0;
    sta_o  <= b;
    sta_oe <= drv;
    repeat (half) @(posedge clk);
    s = mdio_i;
    mdc <= 1'b1;
    repeat (half) @(posedge clk);
  endtask : bit_cyc

  // whole frame, msb first; a fresh preamble every time
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, (rd ? 2'b10 : 2'b01), phy, ra};
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
    // turnaround: released on a read so the device can take the pin
    bit_cyc(1'b1, !rd, s);
    bit_cyc(1'b0, !rd, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], !rd, s);
      rdat[i] = s;
    end
    // park the clock; the wait lets a write land before anyone looks
    @(posedge clk);
    mdc    <= 1'b0;
    sta_oe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : plsaic_sta
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for indicator, error counter and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [4:0] PHY   = 5'h03;
  localparam logic [4:0] A_SEL = plsaic_pkg::REG_IND_SEL;
  localparam logic [4:0] A_CNT = plsaic_pkg::REG_RXERR_CNT;
  localparam logic [4:0] A_CTL = plsaic_pkg::REG_IRQ_CTL;
  localparam logic [4:0] A_FLG = plsaic_pkg::REG_IRQ_FLAG;
  localparam int         LIMIT = 80000;

  logic        clk;
  logic        sys_rst;
  logic        mdc;
  logic        mdio_i;
  logic        mdio_o;
  logic        mdio_oe;
  logic        rmii_mode;
  logic        rx_error;
  logic [10:0] irq_cond;
  logic [3:0]  ind_out;
  logic        irq_o;
  logic        irq_oe;
  logic [6:0]  src;
  logic [6:0]  pat [2];
  logic [2:0]  cd;
  logic [3:0]  ex;
  logic [15:0] bit_n;
  logic [15:0] rv;
  int          n_errors;
  int          tests_run;
  int          cycles;
  wire         link_ok, activity, tx_active, rx_active, collision, speed_100, full_duplex;

  // indicator sources come from one vector for table-driven checks
  assign {full_duplex, speed_100, collision, rx_active, tx_active, activity, link_ok} = src;

  plsaic_top #(.PHY_ADDR(PHY)) plsaic_top_inst (
    .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .link_ok(link_ok), .activity(activity), .tx_active(tx_active),
    .rx_active(rx_active), .collision(collision), .speed_100(speed_100),
    .full_duplex(full_duplex), .rmii_mode(rmii_mode), .rx_error(rx_error),
    .irq_cond(irq_cond), .ind_out(ind_out), .irq_o(irq_o), .irq_oe(irq_oe));

  plsaic_sta sta_inst (.clk(clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_i(mdio_i));

  // free-running clock
  always #2.5 clk = ~clk;

  // hang guard, sized well above the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // wait, then step past the edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    sta_inst.frame(1'b0, PHY, ra, d, x);
  endtask : wr

  task automatic rchk(input string what, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    sta_inst.frame(1'b1, PHY, ra, 16'h0000, d);
    chk(what, exp, d);
  endtask : rchk

  task automatic cond(input logic [10:0] v);
    @(posedge clk);
    irq_cond <= v;
    wt(3);
  endtask : cond

  task automatic errs(input int n);
    @(posedge clk);
    rx_error <= 1'b1;
    repeat (n) @(posedge clk);
    rx_error <= 1'b0;
  endtask : errs

  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    src = 7'h00;
    rmii_mode = 1'b0;
    rx_error = 1'b0;
    irq_cond = 11'h000;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    pat = '{7'h55, 7'h2a};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    src <= 7'h7e;
    wt(4);
    chk("irq_oe reset", 16'h0000, 16'(irq_oe));
    chk("irq_o idle", 16'h0001, 16'(irq_o));
    chk("ind reset", 16'h0003, 16'(ind_out));
    @(posedge clk);
    src <= 7'h5d;
    wt(3);
    chk("ind reset off", 16'h0000, 16'(ind_out));
    rchk("sel reset", A_SEL, 16'h0fe9);
    sta_inst.half = 9;
    rchk("cnt reset", A_CNT, 16'h0000);
    sta_inst.half = 5;
    rchk("ctl reset", A_CTL, 16'h0000);
    rchk("flag reset", A_FLG, 16'h0000);
    // every select code on all four indicators, both source levels
    for (int c = 0; c < 8; c++) begin
      cd = 3'(c);
      wr(A_SEL, {4'hf, cd, cd, cd, cd});
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        src <= pat[k];
        wt(3);
        ex = (cd == 3'h7) ? {3'h0, pat[k][0]} : {4{pat[k][cd]}};
        chk("ind code", 16'(ex), 16'(ind_out));
      end
    end
    rchk("sel readback", A_SEL, 16'h0fff);
    @(posedge clk);
    src <= 7'h01;
    wt(3);
    chk("first shows link", 16'h0001, 16'(ind_out));
    // error counter: counts only in reduced-pin mode, then saturates
    @(posedge clk);
    rmii_mode <= 1'b1;
    errs(10);
    rchk("cnt count", A_CNT, 16'h000a);
    @(posedge clk);
    rmii_mode <= 1'b0;
    errs(5);
    rchk("cnt gated", A_CNT, 16'h000a);
    wr(A_CNT, 16'hfffe);
    @(posedge clk);
    rmii_mode <= 1'b1;
    errs(3);
    rchk("cnt sat", A_CNT, 16'hffff);
    // pin enable and polarity; flag survives its condition
    wr(A_CTL, 16'h8001);
    wt(2);
    chk("irq_oe on", 16'h0001, 16'(irq_oe));
    cond(11'h001);
    chk("irq low-active", 16'h0000, 16'(irq_o));
    cond(11'h000);
    rchk("flag held", A_FLG, 16'h0001);
    rchk("flag kept on read", A_FLG, 16'h0001);
    wr(A_CTL, 16'ha001);
    wt(2);
    chk("irq high-active", 16'h0001, 16'(irq_o));
    // write-one clear, without and with the hold bit
    cond(11'h001);
    wr(A_FLG, 16'h0001);
    rchk("w1c clears", A_FLG, 16'h0000);
    chk("irq released", 16'h0000, 16'(irq_o));
    wr(A_CTL, 16'ha801);
    cond(11'h000);
    cond(11'h001);
    wr(A_FLG, 16'h0001);
    rchk("hold keeps", A_FLG, 16'h0001);
    cond(11'h000);
    wr(A_FLG, 16'h0001);
    rchk("hold gone", A_FLG, 16'h0000);
    // read clear returns the flag, then it is gone
    wr(A_CTL, 16'he001);
    cond(11'h001);
    cond(11'h000);
    rchk("rc first", A_FLG, 16'h0001);
    rchk("rc second", A_FLG, 16'h0000);
    // auto clear follows the condition down
    wr(A_CTL, 16'hb001);
    cond(11'h001);
    rchk("auto while high", A_FLG, 16'h0001);
    cond(11'h000);
    rchk("auto cleared", A_FLG, 16'h0000);
    wr(A_CTL, 16'h0000);
    wt(2);
    chk("irq_oe off", 16'h0000, 16'(irq_oe));
    // foreign address ignored, unmapped offset reads zero
    sta_inst.frame(1'b0, PHY ^ 5'h01, A_CTL, 16'hffff, rv);
    rchk("foreign write", A_CTL, 16'h0000);
    // foreign read leaves the pin to the pull-up
    sta_inst.frame(1'b1, PHY ^ 5'h01, A_SEL, 16'h0000, rv);
    chk("foreign read", 16'hffff, rv);
    chk("mdio_oe idle", 16'h0000, 16'(mdio_oe));
    rchk("unmapped", 5'h1f, 16'h0000);
    // each event gated by its own enable only
    for (int n = 0; n < 11; n++) begin
      bit_n = 16'h0001 << n;
      wr(A_CTL, 16'ha000 | (16'h0001 << ((n + 1) % 11)));
      cond(bit_n[10:0]);
      cond(11'h000);
      chk("irq other enable", 16'h0000, 16'(irq_o));
      wr(A_CTL, 16'ha000 | bit_n);
      wt(2);
      chk("irq own enable", 16'h0001, 16'(irq_o));
      wr(A_FLG, bit_n);
      wt(2);
      chk("irq after clear", 16'h0000, 16'(irq_o));
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
